// [wd_runaway.sv]
// Program run-away watchdog with restart/disable decode and reset pin.
`timescale 1ns/1ns

module wd_runaway (
   // Clock and synchronous system reset
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   // Core side: instruction clock and decoded instructions
   input  wire logic        instr_tick,
   input  wire logic        instr_exec,
   input  wire logic        wd_restart_instruction,
   input  wire logic        wd_disable_instruction,
   input  wire logic        ram_backup_entry,
   output logic             skip_next,
   // Status
   output logic             wd_function_enable_flag,
   output logic             wd_first_underflow_flag,
   output logic             wd_second_underflow_flag,
   output logic             wd_reset,
   // Open-drain reset pin
   output logic             reset_pin_o,
   output logic             reset_pin_oe_n
);

   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic [wd_pkg::CNT_W-1:0] wd_count;
   logic                     underflow;
   logic                     en_r;
   logic                     flag1_r;
   logic                     flag2_r;
   logic                     rst_out_r;
   logic                     skip_r;
   logic                     dis_pend_r;
   wire                      restart;
   wire                      disable_ex;
   wire                      restart_off;
   wire                      count_dec;
   wire                      second_uf;
   wire                      flag1_nxt;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   // The disable needs the restart as the very next instruction, so a
   // pending mark survives only until the next executed instruction.
   assign restart     = instr_exec && wd_restart_instruction;
   assign disable_ex  = instr_exec && wd_disable_instruction;
   assign restart_off = restart && dis_pend_r;
   assign count_dec   = instr_tick && en_r;
   // A restart in the same cycle counts as executed before the underflow.
   assign second_uf   = underflow && flag1_r && !restart;
   // Setting wins over the restart's clear of the first flag.
   assign flag1_nxt   = underflow ? 1'b1 :
                        (restart ? 1'b0 : flag1_r);

   // Counter, reloaded by reset and by RAM back-up entry.
   wd_down_counter #(
      .WIDTH  (wd_pkg::CNT_W),
      .RELOAD (wd_pkg::CNT_RELOAD)
   ) u_cnt (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .load      (ram_backup_entry),
      .dec       (count_dec),
      .count     (wd_count),
      .underflow (underflow)
   );

   // ------------------------------------------------------------
   // Enable flag and disable pairing
   // ------------------------------------------------------------
   // Back-up entry re-enables; software must disable again on return.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         en_r       <= wd_pkg::EN_RESET;
         dis_pend_r <= 1'b0;
      end else begin
         if (ram_backup_entry) begin
            en_r <= 1'b1;
         end else if (restart_off) begin
            en_r <= 1'b0;
         end
         if (instr_exec) begin
            dis_pend_r <= disable_ex;
         end
      end
   end

   // ------------------------------------------------------------
   // Underflow flags, skip and reset request
   // ------------------------------------------------------------
   // The reset request holds until the system reset it causes arrives.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         flag1_r   <= wd_pkg::FLAG_RESET;
         flag2_r   <= wd_pkg::FLAG_RESET;
         rst_out_r <= 1'b0;
         skip_r    <= 1'b0;
      end else begin
         flag1_r   <= ram_backup_entry ? 1'b0 : flag1_nxt;
         skip_r    <= restart && flag1_r;
         if (second_uf) begin
            flag2_r   <= 1'b1;
            rst_out_r <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // The pin is only ever pulled low; the enable is active low.
   assign reset_pin_o              = 1'b0;
   assign reset_pin_oe_n           = !rst_out_r;
   assign wd_reset                 = rst_out_r;
   assign skip_next                = skip_r;
   assign wd_function_enable_flag  = en_r;
   assign wd_first_underflow_flag  = flag1_r;
   assign wd_second_underflow_flag = flag2_r;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_count_dec;
      @(posedge clk_sys) disable iff (!rst_n)
      (count_dec && !ram_backup_entry && wd_count != '0)
         |=> wd_count == $past(wd_count) - 16'h0001;
   endproperty
   a_count_dec: assert property (p_count_dec)
      else $error("Counter did not step down by one.");

   property p_first_flag;
      @(posedge clk_sys) disable iff (!rst_n)
      (count_dec && wd_count == '0 && !ram_backup_entry)
         |=> wd_first_underflow_flag && wd_count == 16'hffff;
   endproperty
   a_first_flag: assert property (p_first_flag)
      else $error("Underflow did not set first flag.");

   property p_second;
      @(posedge clk_sys) disable iff (!rst_n)
      (underflow && flag1_r && !restart)
         |=> wd_second_underflow_flag && wd_reset;
   endproperty
   a_second: assert property (p_second)
      else $error("Second underflow did not request reset.");

   property p_pin;
      @(posedge clk_sys) disable iff (!rst_n)
      wd_reset |-> !reset_pin_oe_n && !reset_pin_o;
   endproperty
   a_pin: assert property (p_pin)
      else $error("Reset pin not pulled low.");

   property p_backup_en;
      @(posedge clk_sys) disable iff (!rst_n)
      ram_backup_entry |=> wd_function_enable_flag
         && !wd_first_underflow_flag && wd_count == 16'hffff;
   endproperty
   a_backup_en: assert property (p_backup_en)
      else $error("Back-up entry did not initialise watchdog.");

   // Helper mark of the last executed instruction, kept apart from the
   // pairing register so that any number of idle cycles is covered.
   logic chk_dis_r;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         chk_dis_r <= 1'b0;
      end else if (instr_exec) begin
         chk_dis_r <= wd_disable_instruction;
      end
   end

   property p_off;
      @(posedge clk_sys) disable iff (!rst_n)
      (restart && chk_dis_r && !ram_backup_entry)
         |=> !wd_function_enable_flag;
   endproperty
   a_off: assert property (p_off)
      else $error("Disable then restart did not disable.");

   property p_dis_alone;
      @(posedge clk_sys) disable iff (!rst_n)
      (disable_ex && !restart_off && en_r) |=> en_r;
   endproperty
   a_dis_alone: assert property (p_dis_alone)
      else $error("Lone disable changed the enable flag.");

   property p_skip;
      @(posedge clk_sys) disable iff (!rst_n)
      (restart && flag1_r && !underflow && !ram_backup_entry)
         |=> skip_next && !wd_first_underflow_flag;
   endproperty
   a_skip: assert property (p_skip)
      else $error("Restart with flag set did not skip.");

   property p_no_skip;
      @(posedge clk_sys) disable iff (!rst_n)
      (restart && !flag1_r) |=> !skip_next;
   endproperty
   a_no_skip: assert property (p_no_skip)
      else $error("Restart with flag clear skipped.");

   property p_sys_reset;
      @(posedge clk_sys)
      !rst_n |=> !wd_first_underflow_flag && !wd_second_underflow_flag
         && wd_count == 16'hffff && wd_function_enable_flag;
   endproperty
   a_sys_reset: assert property (p_sys_reset)
      else $error("System reset did not initialise watchdog.");

   c_underflow: cover property (@(posedge clk_sys) disable iff (!rst_n)
      underflow);
   c_wd_reset: cover property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(wd_reset));
   c_off: cover property (@(posedge clk_sys) disable iff (!rst_n)
      restart_off);
   c_skip_dis: cover property (@(posedge clk_sys) disable iff (!rst_n)
      restart && flag1_r && !en_r);

endmodule : wd_runaway

// [wd_pkg.sv]
// Package with the constants shared by the watchdog files.
package wd_pkg;

   // ------------------------------------------------------------
   // Counter geometry and values after reset
   // ------------------------------------------------------------
   localparam int          CNT_W      = 16;
   localparam logic [15:0] CNT_RELOAD = 16'hffff;
   localparam logic [15:0] CNT_ZERO   = 16'h0000;

   // ------------------------------------------------------------
   // Flag values after system reset
   // ------------------------------------------------------------
   localparam logic        EN_RESET   = 1'b1;
   localparam logic        FLAG_RESET = 1'b0;

endpackage : wd_pkg

// [wd_down_counter.sv]
// Down-counter of the watchdog, with reload and underflow wrap.
`timescale 1ns/1ns

module wd_down_counter #(
   parameter int                 WIDTH  = wd_pkg::CNT_W,
   parameter logic [WIDTH-1:0]   RELOAD = wd_pkg::CNT_RELOAD
) (
   // Clock and synchronous reset
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   // Control
   input  wire logic             load,
   input  wire logic             dec,
   // State
   output logic [WIDTH-1:0]      count,
   output logic                  underflow
);

   logic [WIDTH-1:0] count_r;
   logic [WIDTH-1:0] count_nxt;
   wire              at_zero;

   // ------------------------------------------------------------
   // Next count
   // ------------------------------------------------------------
   // Load outranks a count pulse so a reload never loses a cycle.
   assign at_zero   = (count_r == '0);
   assign count_nxt = load ? RELOAD : (count_r - WIDTH'(1));
   assign underflow = dec && !load && at_zero;
   assign count     = count_r;

   // A count pulse at zero wraps to all ones, the underflow event.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         count_r <= RELOAD;
      end else if (load || dec) begin
         count_r <= count_nxt;
      end
   end

endmodule : wd_down_counter

// [wd_core_model.sv]
// Core-side model that issues instructions and count pulses.
`timescale 1ns/1ns

module wd_core_model (
   // Requests from the bench
   input  wire logic       req,
   input  wire logic [1:0] kind,
   input  wire logic [1:0] noise,
   input  wire logic       tick_en,
   // Instruction stream towards the watchdog
   output logic            instr_tick,
   output logic            instr_exec,
   output logic            wd_restart_instruction,
   output logic            wd_disable_instruction
);
   // Qualifiers carry junk between instructions, so a design that
   // decodes them without the execute strobe is caught.
   assign instr_exec             = req;
   assign wd_restart_instruction = req ? kind == 2'h1 : noise[0];
   assign wd_disable_instruction = req ? kind == 2'h2 : noise[1];
   assign instr_tick             = tick_en;
endmodule : wd_core_model

// [wd_runaway_tb.sv]
// Self-checking bench for the run-away watchdog.
`timescale 1ns/1ns

module wd_runaway_tb;
   logic        clk_sys, rst_n, req, tick_en, bkp;
   logic        ex_d = 1'b0;
   logic [1:0]  kind;
   logic [15:0] lf = 16'h085f;
   logic        instr_tick, instr_exec, skip_next, f1, f2, wdr;
   logic        wd_restart_instruction, wd_disable_instruction;
   logic        en_f, pin_o, pin_oe_n, en_m, f1_m, dis_m;
   logic [6:0]  expq[$];
   int          errors, check_count, cnt_m;

   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   wd_core_model u_wd_core_model (
      .req(req), .kind(kind), .noise(lf[1:0]), .tick_en(tick_en),
      .instr_tick(instr_tick), .instr_exec(instr_exec),
      .wd_restart_instruction(wd_restart_instruction),
      .wd_disable_instruction(wd_disable_instruction));

   wd_runaway u_wd_runaway (
      .clk_sys(clk_sys), .rst_n(rst_n), .instr_tick(instr_tick),
      .instr_exec(instr_exec),
      .wd_restart_instruction(wd_restart_instruction),
      .wd_disable_instruction(wd_disable_instruction),
      .ram_backup_entry(bkp), .skip_next(skip_next),
      .wd_function_enable_flag(en_f), .wd_first_underflow_flag(f1),
      .wd_second_underflow_flag(f2), .wd_reset(wdr),
      .reset_pin_o(pin_o), .reset_pin_oe_n(pin_oe_n));

   task automatic check(input logic [6:0] seen, input logic [6:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // Each executed instruction shows its result one cycle later.
   always @(posedge clk_sys) begin
      ex_d <= instr_exec;
      lf   <= lfsr(lf);
      if (ex_d) begin
         if (expq.size() == 0) check(7'h7f, 7'h00);
         else check({skip_next, en_f, f1, f2, wdr, pin_o, pin_oe_n},
                    expq.pop_front());
      end
   end

   // ----------------------------------------------------------
   // Stimulus tasks with the expected state worked out alongside
   // ----------------------------------------------------------
   task automatic exec(input logic [1:0] k);
      logic sk;
      sk = (k == 2'h1) && f1_m;
      if (k == 2'h1) begin
         if (dis_m) en_m = 1'b0;
         f1_m = 1'b0;
      end
      dis_m = (k == 2'h2);
      expq.push_back({sk, en_m, f1_m, 4'h1});
      @(posedge clk_sys);
      req  <= 1'b1;
      kind <= k;
      @(posedge clk_sys);
      req <= 1'b0;
   endtask : exec

   task automatic ticks(input int n);
      @(posedge clk_sys);
      tick_en <= 1'b1;
      repeat (n) begin
         @(posedge clk_sys);
         if (en_m && cnt_m == 0) begin
            f1_m  = 1'b1;
            cnt_m = 65535;
         end else if (en_m) begin
            cnt_m--;
         end
      end
      tick_en <= 1'b0;
   endtask : ticks

   task automatic print_verdict();
      if (errors == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : print_verdict

   initial begin
      rst_n = 1'b0;
      req = 1'b0;
      kind = 2'h0;
      tick_en = 1'b0;
      bkp = 1'b0;
      errors = 0;
      check_count = 0;
      en_m = 1'b1;
      f1_m = 1'b0;
      dis_m = 1'b0;
      cnt_m = 65535;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      exec(2'h0);
      exec(2'h1);
      exec(2'h2);
      exec(2'h0);
      ticks(65535);
      exec(2'h0);
      ticks(1);
      exec(2'h0);
      exec(2'h1);
      exec(2'h0);
      exec(2'h2);
      repeat (int'(lf[1:0])) @(posedge clk_sys);
      exec(2'h1);
      exec(2'h1);
      // A second system reset must turn the disabled watchdog back on.
      @(posedge clk_sys);
      rst_n <= 1'b0;
      @(posedge clk_sys);
      rst_n <= 1'b1;
      en_m  = 1'b1;
      f1_m  = 1'b0;
      dis_m = 1'b0;
      cnt_m = 65535;
      exec(2'h0);
      @(posedge clk_sys);
      bkp <= 1'b1;
      @(posedge clk_sys);
      bkp <= 1'b0;
      en_m = 1'b1;
      f1_m = 1'b0;
      cnt_m = 65535;
      exec(2'h0);
      repeat (4) @(posedge clk_sys);
      if (expq.size() != 0) errors++;
      print_verdict();
   end
endmodule : wd_runaway_tb
